// ===== rtl/fres_consts.svh
// constants of the flash row erase / program sequencer
// assumes inclusion by bare name from rtl files
`ifndef FRES_CONSTS_SVH
`define FRES_CONSTS_SVH

// register byte offsets
`define FRES_OFS_CTRL      12'h000
`define FRES_OFS_KEY       12'h004
`define FRES_OFS_PAGE      12'h008
`define FRES_OFS_ADDR      12'h00c
`define FRES_OFS_BUF       12'h010
`define FRES_OFS_STAT      12'h014
`define FRES_OFS_DATA      12'h018

// control register fields
`define FRES_BIT_START     15
`define FRES_BIT_NVM_WRITE_ENABLE_BIT      14
`define FRES_BIT_ERASE     6
`define FRES_OP_LSB        0
`define FRES_OP_W          4
`define FRES_OP_ROW        4'h1
`define FRES_OP_PAGE       4'h2
`define FRES_CTRL_MASK     16'h404f

// unlock keys
`define FRES_KEY_FIRST     8'h55
`define FRES_KEY_SECOND    8'haa

// geometry
`define FRES_ROW_WORDS     64
`define FRES_PAGE_ROWS     8

// operation times in ns and derived cycles at 8 ns
`define FRES_CLK_NS        8
`define FRES_ERASE_NS      64
`define FRES_PROG_NS       32
`define FRES_ERASE_CYC     ((`FRES_ERASE_NS + `FRES_CLK_NS - 1) / `FRES_CLK_NS)
`define FRES_PROG_CYC      ((`FRES_PROG_NS + `FRES_CLK_NS - 1) / `FRES_CLK_NS)

`endif

// ===== rtl/fres_pkg.sv
// types of the flash row erase / program sequencer
// assumes nothing of its surroundings
package fres_pkg;
    typedef enum logic [1:0] {
        FRES_KEY_IDLE,
        FRES_KEY_GOT55,
        FRES_KEY_ARMED
    } fres_key_t;

    typedef enum logic [1:0] {
        FRES_IDLE,
        FRES_ERASE,
        FRES_PROG
    } fres_seq_t;
endpackage

// ===== rtl/fres_unlock_if.sv
// carrier between the sequencer top and its key unit
// assumes one clock domain
`timescale 1ns/10ps
`default_nettype none
interface fres_unlock_if;
    logic       key_write;
    logic [7:0] key_data;
    logic       other_write;
    logic       consume;
    logic       armed;
    modport top (output key_write, key_data, other_write, consume,
                 input armed);
    modport unit (input key_write, key_data, other_write, consume,
                  output armed);
endinterface
`default_nettype wire

// ===== rtl/fres_unlock.sv
// unlock key watcher: arms only after 0x55 then 0xaa with no other register write between
// assumes single-cycle write strobes from the register slave
`timescale 1ns/10ps
`default_nettype none
`include "fres_consts.svh"
module fres_unlock (
    // clock and reset
    input wire logic    pclk,
    input wire logic    presetn,
    // link to top
    fres_unlock_if.unit u
);
    typedef struct packed {
        fres_pkg::fres_key_t st;
    } fres_unlock_state_t;

    fres_unlock_state_t s;
    fres_unlock_state_t next_s;

    always_comb begin
        next_s = s;
        if (u.consume || u.other_write) begin
            next_s.st = fres_pkg::FRES_KEY_IDLE;
        end else if (u.key_write) begin
            case (s.st)
                fres_pkg::FRES_KEY_IDLE: begin
                    if (u.key_data == `FRES_KEY_FIRST) begin
                        next_s.st = fres_pkg::FRES_KEY_GOT55;
                    end
                end
                fres_pkg::FRES_KEY_GOT55: begin
                    if (u.key_data == `FRES_KEY_SECOND) begin
                        next_s.st = fres_pkg::FRES_KEY_ARMED;
                    end else if (u.key_data == `FRES_KEY_FIRST) begin
                        next_s.st = fres_pkg::FRES_KEY_GOT55;
                    end else begin
                        next_s.st = fres_pkg::FRES_KEY_IDLE;
                    end
                end
                default: begin
                    if (u.key_data == `FRES_KEY_FIRST) begin
                        next_s.st = fres_pkg::FRES_KEY_GOT55;
                    end else begin
                        next_s.st = fres_pkg::FRES_KEY_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '{st: fres_pkg::FRES_KEY_IDLE};
        end else begin
            s <= next_s;
        end
    end

    assign u.armed = (s.st == fres_pkg::FRES_KEY_ARMED);
endmodule
`default_nettype wire

// ===== rtl/fres_timer.sv
// down counter that times one erase or program cycle
// assumes load is a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
module fres_timer #(
    parameter int CW = 16
) (
    // clock and reset
    input wire logic          pclk,
    input wire logic          presetn,
    // control
    input wire logic          load,
    input wire logic [CW-1:0] count,
    output logic              done
);
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          run;
    } fres_timer_state_t;

    fres_timer_state_t s;
    fres_timer_state_t next_s;

    always_comb begin
        next_s = s;
        if (load) begin
            next_s.cnt = count;
            next_s.run = 1'b1;
        end else if (s.run) begin
            if (s.cnt <= CW'(1)) begin
                next_s.run = 1'b0;
                next_s.cnt = '0;
            end else begin
                next_s.cnt = s.cnt - CW'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign done = s.run && (s.cnt <= CW'(1)) && !load;
endmodule
`default_nettype wire

// ===== rtl/fres_seq.sv
// flash row erase / program sequencer with its apb register slave
// assumes apb master in the same pclk domain; flash array held here as
// an array of words, cpu stall is the cpu_stall output
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "fres_consts.svh"
// How it works
// - program one row, only after page erased; an unerased row still programs and sets err
// - op 0010 plus erase and nvm_write_enable_bit erase page
// - keys 0x55 then 0xaa just before start
// - start bit 15 erases, stalls, self clears
// - op 0001, erase clear, nvm_write_enable_bit select row program
// - 64 word buffer holds one row
// - start in row mode programs, stalls, self clears
module fres_seq #(
    parameter int ROW_WORDS  = `FRES_ROW_WORDS,
    parameter int PAGE_ROWS  = `FRES_PAGE_ROWS,
    parameter int PAGES      = 2,
    parameter int WORD_W     = 24,
    parameter int ERASE_CYC  = `FRES_ERASE_CYC,
    parameter int PROG_CYC   = `FRES_PROG_CYC
) (
    // clock and reset
    input wire logic         pclk,
    input wire logic         presetn,
    // apb slave
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [11:0]  paddr,
    input wire logic [31:0]  pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // cpu side
    output logic             cpu_stall
);
    localparam int RW = $clog2(ROW_WORDS);
    localparam int RC = $clog2(PAGES * PAGE_ROWS);
    localparam int AW = RC + RW;
    localparam int PW = $clog2(PAGES);
    localparam int CW = 16;

    typedef struct packed {
        fres_pkg::fres_seq_t     st;
        logic [15:0]             ctrl;
        logic [7:0]              page;
        logic [15:0]             addr;
        logic [RW-1:0]           bidx;
        logic [RC-1:0]           row;
        logic [PAGES*PAGE_ROWS-1:0] erased;
        logic                    err;
        logic [31:0]             rdata;
        logic                    done;
    } fres_seq_state_t;

    fres_seq_state_t s;
    fres_seq_state_t next_s;

    logic [WORD_W-1:0] row_buf [ROW_WORDS];
    logic [WORD_W-1:0] flash   [PAGES*PAGE_ROWS*ROW_WORDS];

    fres_unlock_if ul ();

    logic           t_load;
    logic [CW-1:0]  t_count;
    logic           t_done;

    // flash row index from the address register; the page register lies above AW bits and drops out
    function automatic logic [RC-1:0] row_of(input logic [7:0] pg,
                                             input logic [15:0] a);
        logic [AW-1:0] w;
        w = AW'({pg, a} >> 1);
        return w[AW-1:RW];
    endfunction

    logic       acc;
    logic       wr;
    logic       hit;
    logic       start_req;
    logic [3:0] op;
    logic [RC-1:0] tgt_row;
    logic [PW-1:0] tgt_page;

    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign hit = (paddr == `FRES_OFS_CTRL) || (paddr == `FRES_OFS_KEY)
              || (paddr == `FRES_OFS_PAGE) || (paddr == `FRES_OFS_ADDR)
              || (paddr == `FRES_OFS_BUF)  || (paddr == `FRES_OFS_STAT)
              || (paddr == `FRES_OFS_DATA);
    assign op = s.ctrl[`FRES_OP_LSB +: `FRES_OP_W];
    assign tgt_row = row_of(s.page, s.addr);
    assign tgt_page = PW'(tgt_row / RC'(PAGE_ROWS));
    assign start_req = wr && (paddr == `FRES_OFS_CTRL)
                    && pwdata[`FRES_BIT_START] && s.st == fres_pkg::FRES_IDLE;

    // key unit hookup; any other register write breaks the key pair
    assign ul.key_write = wr && (paddr == `FRES_OFS_KEY)
                       && s.st == fres_pkg::FRES_IDLE;
    assign ul.key_data = pwdata[7:0];
    assign ul.other_write = wr && (paddr != `FRES_OFS_KEY) && !start_req;
    assign ul.consume = start_req;

    fres_unlock u_unlock (
        .pclk    (pclk),
        .presetn (presetn),
        .u       (ul.unit)
    );

    fres_timer #(.CW(CW)) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (t_load),
        .count   (t_count),
        .done    (t_done)
    );

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        t_load = 1'b0;
        t_count = CW'(ERASE_CYC);
        if (wr && s.st == fres_pkg::FRES_IDLE) begin
            case (paddr)
                `FRES_OFS_CTRL: begin
                    next_s.ctrl = pwdata[15:0] & `FRES_CTRL_MASK;
                    next_s.ctrl[`FRES_BIT_START] = 1'b0;
                    if (pwdata[`FRES_BIT_START] && ul.armed
                        && pwdata[`FRES_BIT_NVM_WRITE_ENABLE_BIT]) begin
                        next_s.ctrl[`FRES_BIT_START] = 1'b1;
                        if (pwdata[`FRES_BIT_ERASE]
                            && pwdata[3:0] == `FRES_OP_PAGE) begin
                            next_s.st = fres_pkg::FRES_ERASE;
                            t_load = 1'b1;
                        end else if (!pwdata[`FRES_BIT_ERASE]
                            && pwdata[3:0] == `FRES_OP_ROW) begin
                            next_s.st = fres_pkg::FRES_PROG;
                            t_count = CW'(PROG_CYC);
                            t_load = 1'b1;
                        end else begin
                            next_s.ctrl[`FRES_BIT_START] = 1'b0;
                            next_s.err = 1'b1;
                        end
                    end
                end
                `FRES_OFS_PAGE: next_s.page = pwdata[7:0];
                `FRES_OFS_ADDR: next_s.addr = pwdata[15:0];
                `FRES_OFS_BUF: next_s.bidx = s.bidx + RW'(1);
                `FRES_OFS_STAT: next_s.err = 1'b0;
                default: ;
            endcase
            if (paddr == `FRES_OFS_CTRL && pwdata[`FRES_BIT_START]
                && next_s.st != fres_pkg::FRES_IDLE) begin
                next_s.row = tgt_row;
            end
        end
        case (s.st)
            fres_pkg::FRES_ERASE: begin
                if (t_done) begin
                    for (int r = 0; r < PAGE_ROWS; r++) begin
                        next_s.erased[RC'(tgt_page) * RC'(PAGE_ROWS)
                                      + RC'(r)] = 1'b1;
                    end
                    next_s.ctrl[`FRES_BIT_START] = 1'b0;
                    next_s.st = fres_pkg::FRES_IDLE;
                end
            end
            fres_pkg::FRES_PROG: begin
                if (t_done) begin
                    if (!s.erased[s.row]) begin
                        next_s.err = 1'b1;
                    end
                    next_s.erased[s.row] = 1'b0;
                    next_s.bidx = '0;
                    next_s.ctrl[`FRES_BIT_START] = 1'b0;
                    next_s.done = 1'b1;
                    next_s.st = fres_pkg::FRES_IDLE;
                end
            end
            default: ;
        endcase
        // capture before the completing edge so the word stands while
        // pready is high; a late capture would hand back the last read
        if (psel && !pwrite && !(penable && pready)) begin
            case (paddr)
                `FRES_OFS_CTRL: next_s.rdata = {16'h0000, s.ctrl};
                `FRES_OFS_PAGE: next_s.rdata = {24'h000000, s.page};
                `FRES_OFS_ADDR: next_s.rdata = {16'h0000, s.addr};
                `FRES_OFS_STAT: next_s.rdata = {30'h0, s.err,
                                   s.st != fres_pkg::FRES_IDLE};
                `FRES_OFS_DATA: next_s.rdata = 32'(flash[AW'({tgt_row,
                                   RW'(s.addr >> 1)})]);
                default: next_s.rdata = 32'h00000000;
            endcase
        end
    end

    // row buffer and array; a row program ands the buffer into erased ones
    always_ff @(posedge pclk) begin
        if (wr && paddr == `FRES_OFS_BUF && s.st == fres_pkg::FRES_IDLE) begin
            row_buf[s.bidx] <= pwdata[WORD_W-1:0];
        end
        if (s.st == fres_pkg::FRES_ERASE && t_done) begin
            for (int i = 0; i < PAGE_ROWS * ROW_WORDS; i++) begin
                flash[AW'(tgt_page) * AW'(PAGE_ROWS * ROW_WORDS)
                      + AW'(i)] <= '1;
            end
        end
        if (s.st == fres_pkg::FRES_PROG && t_done) begin
            for (int i = 0; i < ROW_WORDS; i++) begin
                flash[{s.row, RW'(i)}] <= flash[{s.row, RW'(i)}]
                                        & row_buf[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '{st: fres_pkg::FRES_IDLE, default: '0};
        end else begin
            s <= next_s;
        end
    end

    // the access phase waits out a running cycle, so the cpu really stalls
    assign pready = (s.st == fres_pkg::FRES_IDLE);
    assign pslverr = acc && pready && !hit;
    assign prdata = s.rdata;
    assign cpu_stall = (s.st != fres_pkg::FRES_IDLE);
endmodule
`default_nettype wire

// ===== tb/fres_seq_props.sv
// checker of the sequencer's apb slave and stall output
// assumes binding to fres_seq, one pclk domain
`timescale 1ns/10ps
`default_nettype none
module fres_seq_chk #(
    parameter int ERASE_CYC = 8,
    parameter int PROG_CYC  = 4
) (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // cpu side
    input wire logic        cpu_stall
);
    logic        wr_done;
    logic        rd_done;
    logic        go_key;
    logic        good_op;
    logic        k55;
    logic        kok;
    logic        was_erase;
    logic [15:0] cnt;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign wr_done = psel && penable && pready && pwrite;
    assign rd_done = psel && penable && pready && !pwrite;
    assign good_op = pwdata[14] && (pwdata[6] ? pwdata[3:0] == 4'h2
                                              : pwdata[3:0] == 4'h1);
    assign go_key  = wr_done && paddr == 12'h000 && pwdata[15] && kok;
    // key pair tracker: any completed write re-evaluates it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            k55 <= 1'b0;
            kok <= 1'b0;
            was_erase <= 1'b0;
            cnt <= 16'h0000;
        end else begin
            if (wr_done) begin
                k55 <= paddr == 12'h004 && pwdata[7:0] == 8'h55;
                kok <= paddr == 12'h004 && pwdata[7:0] == 8'haa && k55;
            end
            if (go_key) begin
                cnt <= 16'h0000;
                was_erase <= pwdata[6];
            end else if (cpu_stall) begin
                cnt <= cnt + 16'h0001;
            end
        end
    end
    ready_tracks_a: assert property (
        pready == !cpu_stall)
        else $error("pready not the inverse of stall");
    key_gate_a: assert property (
        $rose(cpu_stall) |-> $past(go_key) && $past(good_op))
        else $error("stall began without keyed start");
    unkeyed_start_a: assert property (
        wr_done && paddr == 12'h000 && pwdata[15] && !kok
        |=> !cpu_stall)
        else $error("unkeyed start ran");
    bad_combo_a: assert property (
        go_key && !good_op |=> !cpu_stall)
        else $error("bad operation combination ran");
    good_go_a: assert property (
        go_key && good_op |=> cpu_stall)
        else $error("keyed start did not stall");
    stall_len_a: assert property (
        $fell(cpu_stall) |-> cnt == (was_erase ? 16'(ERASE_CYC)
                                               : 16'(PROG_CYC)))
        else $error("stall length wrong");
    slverr_map_a: assert property (
        psel && penable && pready
        |-> pslverr == !(paddr[1:0] == 2'h0 && paddr <= 12'h018))
        else $error("error response wrong");
    slverr_idle_a: assert property (
        !(psel && penable) |-> !pslverr)
        else $error("error outside access");
    // read word is captured before the completing edge and then stands
    rdata_hold_a: assert property (
        !(psel && !pwrite && !(penable && pready)) |=> $stable(prdata))
        else $error("read data moved");
endmodule
`default_nettype wire

// ===== tb/fres_cpu_model.sv
// cpu model: software register accesses over apb
// assumes the sequencer slave on the same pclk
`timescale 1ns/10ps
`default_nettype none
module fres_cpu_model (
    // clock
    input wire logic         pclk,
    // apb master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input wire logic [31:0]  prdata,
    input wire logic         pready,
    input wire logic         pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // waits on pready with no assumed latency
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        // read data and response are taken at the completing edge only
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released bus shows junk so stale values cannot pass
        paddr <= ~a;
        pwdata <= ~d;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        xfer(1'b1, a, d, q, e);
    endtask
    // key pair with no other access between
    task automatic unlock();
        wr(12'h004, 32'h55);
        wr(12'h004, 32'haa);
    endtask
endmodule
`default_nettype wire

// ===== tb/fres_seq_tb.sv
// self-checking bench of the sequencer
// assumes fres_seq, fres_cpu_model and the checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module fres_seq_tb;
    localparam int ERASE_CYC = 8;
    localparam int PROG_CYC  = 4;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cpu_stall;
    int          mismatches;
    int          checks;
    int          cyc;
    fres_seq #(.ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cpu_stall(cpu_stall));
    fres_cpu_model cpu_u (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    always #4 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        logic e;
        cpu_u.xfer(1'b0, a, 32'h0, q, e);
    endtask
    // writes control and counts the cycles the cpu is held
    task automatic start(input logic [31:0] c, output logic [31:0] n);
        cpu_u.wr(12'h000, c);
        n = 32'h0;
        // the stall shows only after the completing edge has settled
        @(negedge pclk);
        while (cpu_stall === 1'b1) begin
            n++;
            @(negedge pclk);
        end
    endtask
    task automatic t_unkeyed();
        logic [31:0] n;
        logic [31:0] q;
        start(32'hc042, n);
        cmp(n, 32'h0);
        rd(12'h000, q);
        cmp(q, 32'h4042);
        $display("test unkeyed done");
    endtask
    task automatic t_erase();
        logic [31:0] n;
        logic [31:0] q;
        cpu_u.wr(12'h000, 32'h4042);
        cpu_u.wr(12'h008, 32'h0);
        cpu_u.wr(12'h00c, 32'h0);
        cpu_u.unlock();
        start(32'hc042, n);
        cmp(n, ERASE_CYC);
        rd(12'h000, q);
        cmp(q, 32'h4042);
        $display("test erase done");
    endtask
    task automatic t_prog();
        logic [31:0] n;
        logic [31:0] q;
        cpu_u.wr(12'h000, 32'h4001);
        for (int k = 0; k < 64; k++) begin
            cpu_u.wr(12'h010, 32'h5a0000 | k);
        end
        cpu_u.unlock();
        start(32'hc001, n);
        cmp(n, PROG_CYC);
        rd(12'h000, q);
        cmp(q, 32'h4001);
        for (int k = 0; k < 64; k += 63) begin
            cpu_u.wr(12'h00c, 2 * k);
            rd(12'h018, q);
            cmp(q, 32'h5a0000 | k);
        end
        rd(12'h014, q);
        cmp(q, 32'h0);
        cpu_u.unlock();
        start(32'hc001, n);
        rd(12'h014, q);
        cmp(q, 32'h2);
        cpu_u.wr(12'h014, 32'h2);
        $display("test program done");
    endtask
    task automatic t_refused();
        logic [31:0] n;
        logic [31:0] q;
        logic [31:0] bad [2] = '{32'hc041, 32'hc002};
        logic        e;
        cpu_u.wr(12'h004, 32'h55);
        cpu_u.wr(12'h008, 32'h0);
        cpu_u.wr(12'h004, 32'haa);
        start(32'hc042, n);
        cmp(n, 32'h0);
        foreach (bad[i]) begin
            cpu_u.unlock();
            start(bad[i], n);
            cmp(n, 32'h0);
            rd(12'h014, q);
            cmp(q, 32'h2);
            cpu_u.wr(12'h014, 32'h2);
        end
        cpu_u.xfer(1'b0, 12'h020, 32'h0, q, e);
        cmp({31'h0, e}, 32'h1);
        $display("test refused done");
    endtask
    // keep a word, erase the page, then write two rows back in turn
    task automatic t_rewrite();
        logic [31:0] n;
        logic [31:0] q;
        cpu_u.wr(12'h00c, 32'h7e);
        rd(12'h018, q);
        cmp(q, 32'h5a003f);
        cpu_u.wr(12'h000, 32'h4042);
        cpu_u.unlock();
        start(32'hc042, n);
        cmp(n, ERASE_CYC);
        for (int r = 0; r < 2; r++) begin
            cpu_u.wr(12'h00c, 32'h80 * r);
            for (int k = 0; k < 64; k++) begin
                cpu_u.wr(12'h010, 32'h5a003f ^ r);
            end
            cpu_u.wr(12'h000, 32'h4001);
            cpu_u.unlock();
            start(32'hc001, n);
            cmp(n, PROG_CYC);
            rd(12'h018, q);
            cmp(q, 32'h5a003f ^ r);
        end
        rd(12'h014, q);
        cmp(q, 32'h0);
        $display("test rewrite done");
    endtask
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        mismatches = 0;
        checks = 0;
        cyc = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_unkeyed();
        t_erase();
        t_prog();
        t_refused();
        t_rewrite();
        final_report();
    end
endmodule
bind fres_seq fres_seq_chk #(.ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC))
    chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_stall(cpu_stall));
`default_nettype wire
